// ---- src/sqc_pkg.sv ----
// Constants shared by the dual-channel conversion sequencer, its controller model and its testbench.
// Assumes a single 50 MHz system clock; all pin timing is converted to cycles here.
package sqc_pkg;

    // System clock period
    localparam int CLK_PERIOD_NS = 20;

    // Track-to-hold delay after the trigger edge (typical), and its cycle count
    localparam int APERTURE_NS   = 10;
    localparam int APERTURE_CYC  = ((APERTURE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1) ? 1 :
                                   (APERTURE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Conversion geometry
    localparam int RES_BITS      = 18;
    localparam int STEP_COUNT    = 19;
    localparam int STEP_W        = 5;
    localparam int WORD_W        = 2 * RES_BITS;

    // Step counter values
    localparam logic [STEP_W-1:0] STEP_IDLE = 5'h00;
    localparam logic [STEP_W-1:0] STEP_LAST = 5'h13;
    localparam logic [STEP_W-1:0] STEP_LSB  = 5'h12;
    localparam logic [STEP_W-1:0] STEP_ONE  = 5'h01;

    // Reset values and the trial start value
    localparam logic [RES_BITS-1:0] SAR_RESET   = 18'h00000;
    localparam logic [RES_BITS-1:0] TRIAL_RESET = 18'h00000;
    localparam logic [RES_BITS-1:0] TRIAL_MSB   = 18'h20000;
    localparam logic [WORD_W-1:0]   WORD_RESET  = 36'h000000000;

    // Sequencer states
    typedef enum logic [0:0] {
        SQC_TRACK = 1'b0,
        SQC_CONV  = 1'b1
    } sqc_state_type;

endpackage

// ---- src/sqc_skid_buffer.sv ----
// Two-entry buffer with valid/ready on both sides; outputs come from flip-flops.
// Assumes the filler honours in_ready and the drainer may hold out_ready low.
`timescale 1ns/10ps
module sqc_skid_buffer #(
    parameter int WIDTH = 36
) (
    input  wire logic             mclk,      // System clock
    input  wire logic             rst_n,     // Async reset, active low
    input  wire logic             ce,        // Clock enable
    input  wire logic             in_valid,  // Word offered
    output logic                  in_ready,  // Room for a word
    input  wire logic [WIDTH-1:0] in_data,   // Offered word
    output logic                  out_valid, // Word available
    input  wire logic             out_ready, // Drainer takes the word
    output logic [WIDTH-1:0]      out_data   // Word presented
);
    logic             out_valid_reg;
    logic             out_valid_next;
    logic [WIDTH-1:0] out_data_reg;
    logic [WIDTH-1:0] out_data_next;
    logic             sp_valid_reg;
    logic             sp_valid_next;
    logic [WIDTH-1:0] sp_data_reg;
    logic [WIDTH-1:0] sp_data_next;
    logic             take_in;

    always_comb begin
        take_in        = in_valid & ~sp_valid_reg;
        out_valid_next = out_valid_reg;
        out_data_next  = out_data_reg;
        sp_valid_next  = sp_valid_reg;
        sp_data_next   = sp_data_reg;
        if (!out_valid_reg || out_ready) begin
            if (sp_valid_reg) begin
                out_valid_next = 1'b1;
                out_data_next  = sp_data_reg;
                sp_valid_next  = 1'b0;
            end else begin
                out_valid_next = take_in;
                if (take_in) begin
                    out_data_next = in_data;
                end
            end
        end else if (take_in) begin
            // Drainer stalled: park the word in the spare slot
            sp_valid_next = 1'b1;
            sp_data_next  = in_data;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            out_valid_reg <= 1'b0;
            out_data_reg  <= '0;
            sp_valid_reg  <= 1'b0;
            sp_data_reg   <= '0;
        end else if (ce) begin
            out_valid_reg <= out_valid_next;
            out_data_reg  <= out_data_next;
            sp_valid_reg  <= sp_valid_next;
            sp_data_reg   <= sp_data_next;
        end
    end

    assign in_ready  = ~sp_valid_reg;
    assign out_valid = out_valid_reg;
    assign out_data  = out_data_reg;
endmodule

// ---- src/sqc_sequencer.sv ----
// Dual-channel successive-approximation sequencer with serial and word outputs.
// Assumes trigger, bit clock and comparator levels arrive asynchronously on pins.
`timescale 1ns/10ps
module sqc_sequencer
    import sqc_pkg::*;
(
    input  wire logic                        mclk,             // 50 MHz system clock
    input  wire logic                        rst_n,            // Async reset, active low
    input  wire logic                        ce,               // Clock enable, freezes all state
    input  wire logic                        convert_trigger,  // Conversion trigger pin
    input  wire logic                        bit_step_clock,   // Bit step clock pin
    input  wire logic                        cmp_a,            // Channel A comparator, 1 keeps bit
    input  wire logic                        cmp_b,            // Channel B comparator, 1 keeps bit
    input  wire logic                        word_ready,       // Receiver takes result word
    output logic                             hold,             // Both channels in hold
    output logic [sqc_pkg::RES_BITS-1:0]     trial_bits,       // One-hot bit under test
    output logic [sqc_pkg::RES_BITS-1:0]     sar_a,            // Channel A kept bits
    output logic [sqc_pkg::RES_BITS-1:0]     sar_b,            // Channel B kept bits
    output logic                             sdata_a,          // Channel A serial data
    output logic                             sdata_b,          // Channel B serial data
    output logic                             word_valid,       // Result word available
    output logic [sqc_pkg::RES_BITS-1:0]     word_a,           // Channel A result
    output logic [sqc_pkg::RES_BITS-1:0]     word_b,           // Channel B result
    output logic                             overrun           // A result was lost
);
    import sqc_pkg::*;

    // Pin synchronisers; stage 1 feeds stage 2 only
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic [1:0] prev_reg;
    logic       trig_evt;
    logic       bsc_evt;
    logic       cmp_a_s;
    logic       cmp_b_s;

    sqc_state_type          state_reg;
    sqc_state_type          state_next;
    logic [STEP_W-1:0]      step_reg;
    logic [STEP_W-1:0]      step_next;
    logic                   hold_reg;
    logic                   hold_next;
    logic [RES_BITS-1:0]    trial_reg;
    logic [RES_BITS-1:0]    trial_next;
    logic [RES_BITS-1:0]    sar_a_reg;
    logic [RES_BITS-1:0]    sar_a_next;
    logic [RES_BITS-1:0]    sar_b_reg;
    logic [RES_BITS-1:0]    sar_b_next;
    logic                   dec_a_reg;
    logic                   dec_a_next;
    logic                   dec_b_reg;
    logic                   dec_b_next;
    logic                   sdata_a_reg;
    logic                   sdata_a_next;
    logic                   sdata_b_reg;
    logic                   sdata_b_next;
    logic                   pend_valid_reg;
    logic                   pend_valid_next;
    logic [WORD_W-1:0]      pend_word_reg;
    logic [WORD_W-1:0]      pend_word_next;
    logic                   overrun_reg;
    logic                   overrun_next;
    logic                   pend_ready;
    logic                   buf_valid;
    logic [WORD_W-1:0]      buf_data;
    logic                   finish;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
            prev_reg  <= 2'h0;
        end else if (ce) begin
            sync1_reg <= {cmp_b, cmp_a, bit_step_clock, convert_trigger};
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg[1:0];
        end
    end

    assign trig_evt = ce & sync2_reg[0] & ~prev_reg[0];
    assign bsc_evt  = ce & sync2_reg[1] & ~prev_reg[1];
    assign cmp_a_s  = sync2_reg[2];
    assign cmp_b_s  = sync2_reg[3];

    always_comb begin
        state_next   = state_reg;
        step_next    = step_reg;
        hold_next    = hold_reg;
        trial_next   = trial_reg;
        sar_a_next   = sar_a_reg;
        sar_b_next   = sar_b_reg;
        dec_a_next   = dec_a_reg;
        dec_b_next   = dec_b_reg;
        sdata_a_next = sdata_a_reg;
        sdata_b_next = sdata_b_reg;
        finish       = 1'b0;
        if (trig_evt) begin
            // new conversion, both channels held together, fixed delay
            state_next = SQC_CONV;
            step_next  = STEP_IDLE;
            hold_next  = 1'b1;
            trial_next = TRIAL_MSB;
            sar_a_next = SAR_RESET;
            sar_b_next = SAR_RESET;
        end else if (bsc_evt && state_reg == SQC_CONV) begin
            // one bit per step, shared by both channels
            step_next  = step_reg + STEP_ONE;
            trial_next = trial_reg >> 1;
            if (step_reg < STEP_LSB) begin
                // MSB decided on the first edge
                sar_a_next = sar_a_reg | (cmp_a_s ? trial_reg : TRIAL_RESET);
                sar_b_next = sar_b_reg | (cmp_b_s ? trial_reg : TRIAL_RESET);
                // MSB inverted turns offset binary into two's complement
                dec_a_next = (step_reg == STEP_IDLE) ? ~cmp_a_s : cmp_a_s;
                dec_b_next = (step_reg == STEP_IDLE) ? ~cmp_b_s : cmp_b_s;
            end
            if (step_reg != STEP_IDLE) begin
                // serial bit one bit clock after its decision
                sdata_a_next = dec_a_reg;
                sdata_b_next = dec_b_reg;
            end
            if (step_reg == STEP_LSB) begin
                // 19th edge returns to track, further edges ignored
                state_next = SQC_TRACK;
                hold_next  = 1'b0;
                finish     = 1'b1;
            end
        end
    end

    // Result word waits here while the buffer is full
    always_comb begin
        pend_valid_next = pend_valid_reg;
        pend_word_next  = pend_word_reg;
        overrun_next    = overrun_reg;
        if (pend_valid_reg && pend_ready) begin
            pend_valid_next = 1'b0;
        end
        if (finish) begin
            if (pend_valid_reg && !pend_ready) begin
                overrun_next = 1'b1;
            end
            pend_valid_next = 1'b1;
            pend_word_next  = {~sar_b_reg[RES_BITS-1], sar_b_reg[RES_BITS-2:0],
                               ~sar_a_reg[RES_BITS-1], sar_a_reg[RES_BITS-2:0]};
        end
    end

    // rest in track with counter idle after reset
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg      <= SQC_TRACK;
            step_reg       <= STEP_IDLE;
            hold_reg       <= 1'b0;
            trial_reg      <= TRIAL_RESET;
            sar_a_reg      <= SAR_RESET;
            sar_b_reg      <= SAR_RESET;
            dec_a_reg      <= 1'b0;
            dec_b_reg      <= 1'b0;
            sdata_a_reg    <= 1'b0;
            sdata_b_reg    <= 1'b0;
            pend_valid_reg <= 1'b0;
            pend_word_reg  <= WORD_RESET;
            overrun_reg    <= 1'b0;
        end else if (ce) begin
            state_reg      <= state_next;
            step_reg       <= step_next;
            hold_reg       <= hold_next;
            trial_reg      <= trial_next;
            sar_a_reg      <= sar_a_next;
            sar_b_reg      <= sar_b_next;
            dec_a_reg      <= dec_a_next;
            dec_b_reg      <= dec_b_next;
            sdata_a_reg    <= sdata_a_next;
            sdata_b_reg    <= sdata_b_next;
            pend_valid_reg <= pend_valid_next;
            pend_word_reg  <= pend_word_next;
            overrun_reg    <= overrun_next;
        end
    end

    sqc_skid_buffer #(
        .WIDTH     (WORD_W)
    ) u_buffer (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .ce        (ce),
        .in_valid  (pend_valid_reg),
        .in_ready  (pend_ready),
        .in_data   (pend_word_reg),
        .out_valid (buf_valid),
        .out_ready (word_ready),
        .out_data  (buf_data)
    );

    assign hold       = hold_reg;
    assign trial_bits = trial_reg;
    assign sar_a      = sar_a_reg;
    assign sar_b      = sar_b_reg;
    assign sdata_a    = sdata_a_reg;
    assign sdata_b    = sdata_b_reg;
    assign word_valid = buf_valid;
    assign word_a     = buf_data[RES_BITS-1:0];
    assign word_b     = buf_data[WORD_W-1:RES_BITS];
    assign overrun    = overrun_reg;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence step_edge_s;
        state_reg == SQC_CONV && bsc_evt && !trig_evt;
    endsequence

    sequence last_edge_s;
        step_edge_s and (step_reg == STEP_LSB);
    endsequence

    track_to_hold_a: assert property (trig_evt |-> ##APERTURE_CYC (hold_reg && step_reg == STEP_IDLE))
        else $error("trigger edge did not start a held conversion");
    co_phase_hold_a: assert property (trig_evt |=> sar_a_reg == SAR_RESET && sar_b_reg == SAR_RESET
                                      && trial_reg == TRIAL_MSB)
        else $error("channels not captured together");
    step_advance_a: assert property (step_edge_s |=> step_reg == $past(step_reg) + STEP_ONE)
        else $error("step counter did not advance on a bit clock edge");
    track_return_a: assert property (last_edge_s |=> !hold_reg && state_reg == SQC_TRACK
                                     && step_reg == STEP_LAST)
        else $error("no return to track on the 19th edge");
    edge_lockout_a: assert property (state_reg == SQC_TRACK && !trig_evt |=> $stable(step_reg)
                                     && $stable(sar_a_reg) && $stable(sdata_a_reg))
        else $error("edge acted on outside a conversion");
    msb_first_a: assert property ((step_edge_s and step_reg == STEP_IDLE)
                                  |=> sar_a_reg[RES_BITS-1] == $past(cmp_a_s))
        else $error("MSB not decided on the first edge");
    serial_delay_a: assert property ((step_edge_s and step_reg == STEP_ONE)
                                     |=> sdata_b_reg == !sar_b_reg[RES_BITS-1])
        else $error("serial MSB not one bit clock after its decision");
    twos_word_a: assert property ($rose(pend_valid_reg) |-> pend_word_reg[RES_BITS-1] == !sar_a_reg[RES_BITS-1]
                                  && pend_word_reg[RES_BITS-2:0] == sar_a_reg[RES_BITS-2:0])
        else $error("result word not in two's complement");
    hold_in_conv_a: assert property (hold_reg |-> state_reg == SQC_CONV && step_reg <= STEP_LSB)
        else $error("hold outside a conversion");
    edge_only_a: assert property (state_reg == SQC_CONV && !bsc_evt && !trig_evt |=> $stable(step_reg))
        else $error("step moved without a rising edge");
endmodule

// ---- verification/sqc_ctrl_model.sv ----
// Controller and comparator model facing the conversion sequencer pins.
// Assumes the bench calls run or clocks; trigger and bit clock pins change on mclk falling edges.
`timescale 1ns/10ps
module sqc_ctrl_model
    import sqc_pkg::*;
#(
    parameter int GUARD_CYC = 6
) (
    input  wire logic                         mclk,            // System clock
    output logic                              convert_trigger, // Conversion trigger pin
    output logic                              bit_step_clock,  // Bit step clock pin
    output logic                              cmp_a,           // Channel A comparator
    output logic                              cmp_b,           // Channel B comparator
    input  wire logic [sqc_pkg::RES_BITS-1:0] trial_bits,      // Bit under test
    input  wire logic [sqc_pkg::RES_BITS-1:0] sar_a,           // Channel A kept bits
    input  wire logic [sqc_pkg::RES_BITS-1:0] sar_b,           // Channel B kept bits
    input  wire logic                         sdata_a,         // Channel A serial data
    input  wire logic                         sdata_b          // Channel B serial data
);
    logic [RES_BITS-1:0] tgt_a = 18'h00000;
    logic [RES_BITS-1:0] tgt_b = 18'h00000;
    logic [RES_BITS-1:0] ser_a = 18'h00000;
    logic [RES_BITS-1:0] ser_b = 18'h00000;

    initial begin
        convert_trigger = 1'b0;
        bit_step_clock  = 1'b0;
    end

    // Held level in offset binary; a bit is kept while the trial stays at or below it
    assign cmp_a = ((sar_a | trial_bits) <= tgt_a);
    assign cmp_b = ((sar_b | trial_bits) <= tgt_b);

    // duty and rate set by caller
    task automatic clocks(input int n, input int hi, input int lo);
        repeat (n) begin
            bit_step_clock = 1'b1;
            repeat (hi) @(negedge mclk);
            bit_step_clock = 1'b0;
            repeat (lo) @(negedge mclk);
        end
    endtask

    task automatic run(input logic [RES_BITS-1:0] a, input logic [RES_BITS-1:0] b,
                       input int nclk, input int hi, input int lo);
        tgt_a = a;
        tgt_b = b;
        @(negedge mclk);
        convert_trigger = 1'b1;
        repeat (4) @(negedge mclk);
        convert_trigger = 1'b0;
        repeat (GUARD_CYC) @(negedge mclk);
        for (int k = 1; k <= nclk; k++) begin
            if (k >= 3) begin
                ser_a = {ser_a[RES_BITS-2:0], sdata_a};
                ser_b = {ser_b[RES_BITS-2:0], sdata_b};
            end
            clocks(1, hi, lo);
        end
    endtask
endmodule

// ---- verification/test_dual_sar_adc_conversion_sequencer.sv ----
// Self-checking bench for the dual-channel conversion sequencer.
// Assumes sqc_ctrl_model plays controller and comparators; bench drains words.
`timescale 1ns/10ps
module test_dual_sar_adc_conversion_sequencer;
    import sqc_pkg::*;
    logic                mclk;
    logic                rst_n;
    logic                ce;
    logic                word_ready;
    logic                convert_trigger;
    logic                bit_step_clock;
    logic                cmp_a;
    logic                cmp_b;
    logic                hold;
    logic [RES_BITS-1:0] trial_bits;
    logic [RES_BITS-1:0] sar_a;
    logic [RES_BITS-1:0] sar_b;
    logic                sdata_a;
    logic                sdata_b;
    logic                word_valid;
    logic [RES_BITS-1:0] word_a;
    logic [RES_BITS-1:0] word_b;
    logic                overrun;
    int                  num_errors = 0;
    int                  num_checks = 0;
    int                  hold_lat   = -1;

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    sqc_sequencer dut_u (.mclk(mclk), .rst_n(rst_n), .ce(ce), .convert_trigger(convert_trigger),
        .bit_step_clock(bit_step_clock), .cmp_a(cmp_a), .cmp_b(cmp_b), .word_ready(word_ready),
        .hold(hold), .trial_bits(trial_bits), .sar_a(sar_a), .sar_b(sar_b), .sdata_a(sdata_a),
        .sdata_b(sdata_b), .word_valid(word_valid), .word_a(word_a), .word_b(word_b), .overrun(overrun));

    sqc_ctrl_model ctl_u (.mclk(mclk), .convert_trigger(convert_trigger), .bit_step_clock(bit_step_clock),
        .cmp_a(cmp_a), .cmp_b(cmp_b), .trial_bits(trial_bits), .sar_a(sar_a), .sar_b(sar_b),
        .sdata_a(sdata_a), .sdata_b(sdata_b));

    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic timed_out();
        num_errors++;
        $display("[FAIL] wait expired");
        finish_test();
    endtask

    task automatic check(input string what, input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic watch_hold();
        int n;
        n = 0;
        while (convert_trigger !== 1'b1 && n < 4) begin
            @(posedge mclk);
            n++;
        end
        if (n == 4) timed_out();
        n = 1;
        @(negedge mclk);
        if (hold === 1'b1) return;
        while (hold !== 1'b1 && n < 8) begin
            @(negedge mclk);
            n++;
        end
        if (n == 8) timed_out();
        if (hold_lat < 0) hold_lat = n;
        check("hold delay", WORD_W'(n), WORD_W'(hold_lat));
        check("hold soon", WORD_W'(n <= 6), WORD_W'(1));
        check("first trial", WORD_W'(trial_bits), WORD_W'(18'h20000));
        check("sar at hold", {sar_b, sar_a}, '0);
    endtask

    task automatic conv(input logic [RES_BITS-1:0] ca, input logic [RES_BITS-1:0] cb, input int hi, input int lo);
        fork
            ctl_u.run(ca ^ 18'h20000, cb ^ 18'h20000, 20, hi, lo);
            watch_hold();
        join
        check("hold after last", WORD_W'(hold), '0);
        check("sar kept", {sar_b, sar_a}, {cb ^ 18'h20000, ca ^ 18'h20000});
        check("serial", {ctl_u.ser_b, ctl_u.ser_a}, {cb, ca});
    endtask

    task automatic get_word(input logic [RES_BITS-1:0] ca, input logic [RES_BITS-1:0] cb);
        int n;
        n = 0;
        while (word_valid !== 1'b1 && n < 10) begin
            @(negedge mclk);
            n++;
        end
        if (n == 10) timed_out();
        check("word", {word_b, word_a}, {cb, ca});
        word_ready = 1'b1;
        @(negedge mclk);
        word_ready = 1'b0;
        @(negedge mclk);
    endtask

    task automatic sc_idle();
        check("reset outputs", WORD_W'({hold, word_valid, overrun, sdata_a, sdata_b}), '0);
        ctl_u.clocks(5, 4, 4);
        check("idle hold", WORD_W'(hold), '0);
        check("idle sar", {trial_bits, sar_a}, '0);
    endtask

    task automatic sc_codes();
        logic [RES_BITS-1:0] tab [4] = '{18'h1ffff, 18'h00000, 18'h3ffff, 18'h20000};
        for (int i = 0; i < 4; i++) begin
            conv(tab[i], tab[3-i], 3 + (i % 2), 6 - 2 * (i % 2));
            get_word(tab[i], tab[3-i]);
        end
    endtask

    task automatic sc_retrigger();
        ctl_u.run(18'h12345, 18'h0abcd, 7, 4, 4);
        check("hold mid", WORD_W'(hold), WORD_W'(1));
        conv(18'h0f0f0, 18'h30303, 4, 4);
        get_word(18'h0f0f0, 18'h30303);
        repeat (4) @(negedge mclk);
        check("no extra word", WORD_W'(word_valid), '0);
    endtask

    task automatic sc_overrun();
        for (int i = 0; i < 4; i++) begin
            conv(RES_BITS'(17 + i), RES_BITS'(262128 - i), 4, 4);
            check("overrun", WORD_W'(overrun), WORD_W'(i == 3));
        end
        // Newest word replaces the one waiting in the pending slot
        for (int i = 0; i < 3; i++) begin
            get_word(RES_BITS'(17 + i + i / 2), RES_BITS'(262128 - i - i / 2));
        end
        repeat (4) @(negedge mclk);
        check("drained", WORD_W'(word_valid), '0);
    endtask

    task automatic sc_freeze();
        ce = 1'b0;
        ctl_u.run(18'h2aaaa, 18'h15555, 20, 4, 4);
        check("frozen", WORD_W'({hold, word_valid}), '0);
        check("frozen sar", {trial_bits, sar_a}, '0);
        ce = 1'b1;
        ctl_u.clocks(2, 4, 4);
        check("thawed", WORD_W'({hold, word_valid}), '0);
    endtask

    task automatic sc_reset_mid();
        fork
            ctl_u.run(18'h2aaaa, 18'h15555, 20, 4, 4);
            begin
                repeat (60) @(negedge mclk);
                rst_n = 1'b0;
                @(negedge mclk);
                rst_n = 1'b1;
            end
        join
        check("mid reset", WORD_W'({hold, word_valid, overrun}), '0);
        check("mid reset sar", {trial_bits, sar_a}, '0);
    endtask

    initial begin
        rst_n      = 1'b0;
        ce         = 1'b1;
        word_ready = 1'b0;
        repeat (3) @(negedge mclk);
        rst_n = 1'b1;
        @(negedge mclk);
        sc_idle();
        sc_codes();
        sc_retrigger();
        sc_overrun();
        sc_reset_mid();
        sc_freeze();
        finish_test();
    end
endmodule
